//--- cfg_host_model.sv
// Host bridge model that issues configuration reads and writes.
// Assumes the block answers each request one cycle after the edge that takes it.
`timescale 1ns/1ps
module cfg_host_model (
	// Clock.
	input wire logic clk,
	// Request.
	output logic cfg_valid,
	output logic cfg_write,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	// Answer.
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack
);
	initial begin
		cfg_valid = 1'h0;
		cfg_write = 1'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// Writes select the power state and clear pending sources.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic ok);
		ok = 1'h0;
		rd = 32'h0;
		@(posedge clk);
		cfg_valid <= 1'h1;
		cfg_write <= w;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= wd;
		@(posedge clk);
		cfg_valid <= 1'h0;
		cfg_addr <= ~a;
		cfg_wdata <= ~wd;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			if (cfg_ack === 1'h1) begin
				ok = 1'h1;
				rd = cfg_rdata;
			end
		end
	endtask
endmodule

//--- cfg_pm_block.sv
// Upper configuration header, power management capability and interrupt merge.
// Assumes a one-cycle configuration request strobe from the bus interface on clk.
`timescale 1ns/1ps
module cfg_pm_block
	import cfg_pm_pkg::*;
#(
	parameter int NSRC = 8,
	parameter int NSTREAM = 8,
	parameter logic [7:0] MIN_GRANT = 8'h00
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Configuration cycles.
	input wire logic cfg_valid,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	// Identity load from external configuration memory.
	input wire logic ident_load,
	input wire logic [31:0] ident_data,
	// Internal events.
	input wire logic pme_event,
	input wire logic [NSRC-1:0] src_event,
	input wire logic [NSTREAM-1:0] buf_event,
	// Host-facing lines and state.
	output logic inta_n,
	output logic pme_out,
	output logic pme_oe_n,
	output power_state_type power_state,
	output logic vc_strobe,
	output logic [$clog2(NSTREAM)-1:0] vc_number
);

	if (NSRC < 1 || NSRC > 32 || NSTREAM < 2 || NSTREAM > 32) begin : param_check_g
		$error("cfg_pm_block: NSRC must be 1..32 and NSTREAM 2..32.");
	end

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	// Merges write data into a value under byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Expands byte enables to a bit mask.
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		return merge(32'h0000_0000, 32'hffff_ffff, be);
	endfunction

	// ----------------------------------------
	// Register state.
	// ----------------------------------------
	logic [31:0] subsys_q, subsys_d;
	logic [7:0] int_line_q, int_line_d;
	logic pme_status_q, pme_status_d;
	logic pme_en_q, pme_en_d;
	logic [1:0] pstate_q, pstate_d;
	logic [NSRC-1:0] src_pend_q, src_pend_d;
	logic [NSTREAM-1:0] vc_pend_q, vc_pend_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic vc_strobe_q, vc_strobe_d;
	logic [$clog2(NSTREAM)-1:0] vc_num_q, vc_num_d;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] pm_csr_word;

	assign wr = cfg_valid && cfg_write;
	assign wmask = be_mask(cfg_be) & cfg_wdata;
	// Data byte, scale and select and reserved bits stay zero.
	assign pm_csr_word = {16'h0000, pme_status_q, 6'h00, pme_en_q, 6'h00, pstate_q};

	always_comb begin
		subsys_d = subsys_q;
		int_line_d = int_line_q;
		pme_en_d = pme_en_q;
		pstate_d = pstate_q;
		pme_status_d = pme_status_q;
		src_pend_d = src_pend_q;
		vc_pend_d = vc_pend_q;
		// Identity is loaded from memory or programmed by the host.
		if (ident_load) begin
			subsys_d = ident_data;
		end else if (wr && cfg_addr == OFS_SUBSYS) begin
			subsys_d = merge(subsys_q, cfg_wdata, cfg_be);
		end
		if (wr && cfg_addr == OFS_INT_LAT && cfg_be[0]) begin
			int_line_d = cfg_wdata[7:0];
		end
		if (wr && cfg_addr == OFS_PM_CSR) begin
			if (cfg_be[1]) begin
				pme_en_d = cfg_wdata[CSR_PME_EN];
				if (cfg_wdata[CSR_PME_STATUS]) begin
					pme_status_d = 1'b0;
				end
			end
			if (cfg_be[0]) begin
				pstate_d = cfg_wdata[CSR_STATE_LO +: 2];
			end
		end
		// A new event wins over a simultaneous clear.
		if (pme_event) begin
			pme_status_d = 1'b1;
		end
		if (wr && cfg_addr == OFS_INT_STATUS) begin
			src_pend_d = src_pend_q & ~wmask[NSRC-1:0];
		end
		if (wr && cfg_addr == OFS_VC_STATUS) begin
			vc_pend_d = vc_pend_q & ~wmask[NSTREAM-1:0];
		end
		src_pend_d = src_pend_d | src_event;
		vc_pend_d = vc_pend_d | buf_event;
	end

	// ----------------------------------------
	// Read path and virtual channel signalling.
	// ----------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		ack_d = cfg_valid;
		if (cfg_valid && !cfg_write) begin
			if (cfg_addr == OFS_SUBSYS) begin
				rdata_d = subsys_q;
			end else if (cfg_addr == OFS_EXP_ROM) begin
				rdata_d = 32'h0000_0000;
			end else if (cfg_addr == OFS_CAP_PTR) begin
				rdata_d = {24'h000000, CAP_POINTER};
			end else if (cfg_addr == OFS_RSVD_38) begin
				rdata_d = 32'h0000_0000;
			end else if (cfg_addr == OFS_INT_LAT) begin
				rdata_d = {MAX_LATENCY, MIN_GRANT, INT_PIN_INTA, int_line_q};
			end else if (cfg_addr == OFS_PM_CAP) begin
				rdata_d = {PM_CAP_VALUE, PM_NEXT_PTR, PM_CAP_ID};
			end else if (cfg_addr == OFS_PM_CSR) begin
				rdata_d = pm_csr_word;
			end else if (cfg_addr == OFS_INT_STATUS) begin
				rdata_d = 32'(src_pend_q);
			end else if (cfg_addr == OFS_VC_STATUS) begin
				rdata_d = 32'(vc_pend_q);
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
		// Lowest stream with an event this cycle is announced.
		vc_strobe_d = |buf_event;
		vc_num_d = vc_num_q;
		for (int i = NSTREAM - 1; i >= 0; i--) begin
			if (buf_event[i]) begin
				vc_num_d = i[$clog2(NSTREAM)-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			subsys_q <= SUBSYS_RESET;
			int_line_q <= INT_LINE_RESET;
			pme_status_q <= 1'b0;
			pme_en_q <= 1'b0;
			pstate_q <= PSTATE_RESET;
			src_pend_q <= '0;
			vc_pend_q <= '0;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			vc_strobe_q <= 1'b0;
			vc_num_q <= '0;
		end else begin
			subsys_q <= subsys_d;
			int_line_q <= int_line_d;
			pme_status_q <= pme_status_d;
			pme_en_q <= pme_en_d;
			pstate_q <= pstate_d;
			src_pend_q <= src_pend_d;
			vc_pend_q <= vc_pend_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			vc_strobe_q <= vc_strobe_d;
			vc_num_q <= vc_num_d;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign cfg_rdata = rdata_q;
	assign cfg_ack = ack_q;
	assign inta_n = ~(|src_pend_q | |vc_pend_q);
	assign pme_out = 1'b0;
	assign pme_oe_n = ~(pme_status_q & pme_en_q);
	assign power_state = power_state_type'(pstate_q);
	assign vc_strobe = vc_strobe_q;
	assign vc_number = vc_num_q;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	sequence cap_read_s;
		cfg_valid && !cfg_write && cfg_addr == OFS_PM_CAP;
	endsequence

	sequence csr_read_s;
		cfg_valid && !cfg_write && cfg_addr == OFS_PM_CSR;
	endsequence

	AST_CAP_HIGH_BITS: assert property (@(posedge clk) disable iff (!nrst)
		cap_read_s |=> cfg_ack && cfg_rdata[31:27] == 5'h0f)
		else $error("Wake support bits of the capability word are wrong.");

	AST_CAP_LOW_BITS: assert property (@(posedge clk) disable iff (!nrst)
		cap_read_s |=> cfg_rdata[26:16] == 11'h62a && cfg_rdata[15:0] == 16'h0001)
		else $error("Capability support, version or header bits are wrong.");

	AST_CSR_ZERO_FIELDS: assert property (@(posedge clk) disable iff (!nrst)
		csr_read_s |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00
		&& cfg_rdata[7:2] == 6'h00)
		else $error("Read-only zero fields of the control word are not zero.");

	AST_PME_STATUS_SET: assert property (@(posedge clk) disable iff (!nrst)
		pme_event |=> pme_status_q ##1 (pme_status_q || $past(wr)))
		else $error("Power event did not set the status flag.");

	AST_PME_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
		wr && cfg_addr == OFS_PM_CSR && cfg_be[1] && cfg_wdata[CSR_PME_STATUS]
		&& !pme_event |=> !pme_status_q)
		else $error("Writing one did not clear the status flag.");

	AST_WAKE_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
		pme_event && pme_en_q && !(wr && cfg_addr == OFS_PM_CSR) |=> !pme_oe_n)
		else $error("Wake drive does not follow status and enable.");

	AST_STATE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
		wr && cfg_addr == OFS_PM_CSR && cfg_be[0] |=> pstate_q == $past(cfg_wdata[1:0])
		&& 2'(power_state) == $past(cfg_wdata[1:0]))
		else $error("Power state write was not taken.");

	AST_INT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		|src_event |=> !inta_n)
		else $error("Interrupt line not asserted after a source event.");

	AST_VC_SIGNAL: assert property (@(posedge clk) disable iff (!nrst)
		buf_event[0] |=> vc_strobe && vc_number == '0)
		else $error("Stream event did not signal its channel number.");

	AST_ID_LOAD: assert property (@(posedge clk) disable iff (!nrst)
		ident_load |=> subsys_q == $past(ident_data))
		else $error("Identity load did not update the subsystem fields.");

	sequence csr_enable_write_s;
		wr && cfg_addr == OFS_PM_CSR && cfg_be[1];
	endsequence

	sequence int_clear_all_s;
		wr && cfg_addr == OFS_INT_STATUS && (src_pend_q & ~wmask[NSRC-1:0]) == '0
		&& !(|src_event) && !(|vc_pend_q) && !(|buf_event);
	endsequence

	sequence src0_clear_s;
		wr && cfg_addr == OFS_INT_STATUS && cfg_be[0] && cfg_wdata[0] && !src_event[0];
	endsequence

	sequence ident_write_s;
		wr && cfg_addr == OFS_SUBSYS && cfg_be == 4'hf && !ident_load;
	endsequence

	AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
		csr_enable_write_s |=> pme_en_q == $past(cfg_wdata[CSR_PME_EN]))
		else $error("Power-event enable write was not taken.");

	AST_PME_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		pme_status_q && !(wr && cfg_addr == OFS_PM_CSR) |=> pme_status_q)
		else $error("Status flag changed without a write.");

	AST_INT_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
		int_clear_all_s |=> inta_n)
		else $error("Interrupt line not released after all sources cleared.");

	AST_SRC_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
		src0_clear_s |=> !src_pend_q[0])
		else $error("Writing one did not clear the pending source.");

	AST_ID_WRITE: assert property (@(posedge clk) disable iff (!nrst)
		ident_write_s |=> subsys_q == $past(cfg_wdata))
		else $error("Host write did not program the subsystem fields.");

	AST_VC_PULSE: assert property (@(posedge clk) disable iff (!nrst)
		!(|buf_event) |=> !vc_strobe)
		else $error("Channel strobe stands longer than one cycle.");

	AST_VC_LOWEST: assert property (@(posedge clk) disable iff (!nrst)
		buf_event[1] && !buf_event[0] |=> vc_strobe && 32'(vc_number) == 32'h1)
		else $error("Stream event did not signal the lowest channel number.");

	AST_RESET_VALUES: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> power_state == PS_ON && inta_n && pme_oe_n && !vc_strobe)
		else $error("Outputs are not at their reset values after reset.");

endmodule

//--- cfg_pm_pkg.sv
// Constants for the upper configuration header, power capability and interrupt merge.
// Assumes byte offsets into configuration space and 32-bit dword accesses.
// What this block does
// - Capability bit 15 reads zero: no wake signalling from cold deep sleep.
// - Capability bits 14 to 11 read one: wake from hot deep sleep to on.
// - Capability bits 10 and 9 read one: both intermediate states supported.
// - Auxiliary current bits 8 to 6 and auxiliary power bit 4 read zero.
// - Capability bit 5 reads one: device-specific init needed after return on.
// - Capability bit 3 reads one: bus clock needed to raise a power event.
// - Capability version bits 2 to 0 read fixed 010.
// - Control/status bit 15 is the power-event status flag, reset zero.
// - Data scale, data select and power data byte read zero.
// - Control/status bit 8 is a writable power-event enable, reset zero.
// - Control/status bits 7 to 2 are reserved and read zero.
// - Power-state field in bits 1-0 is writable, resets to 00.
// - Subsystem identity reads zero unless loaded from memory or host-written.
// - All internal interrupt sources merge onto one shared interrupt line.
// - Host reads which source is pending and clears it.
// - Stream buffer midpoint or wrap signals a virtual channel number, that of the lowest stream with an event that cycle.
package cfg_pm_pkg;
	localparam logic [7:0] OFS_SUBSYS = 8'h2c;
	localparam logic [7:0] OFS_EXP_ROM = 8'h30;
	localparam logic [7:0] OFS_CAP_PTR = 8'h34;
	localparam logic [7:0] OFS_RSVD_38 = 8'h38;
	localparam logic [7:0] OFS_INT_LAT = 8'h3c;
	localparam logic [7:0] OFS_PM_CAP = 8'h40;
	localparam logic [7:0] OFS_PM_CSR = 8'h44;
	localparam logic [7:0] OFS_INT_STATUS = 8'h48;
	localparam logic [7:0] OFS_VC_STATUS = 8'h4c;
	localparam logic [7:0] CAP_POINTER = 8'h40;
	localparam logic [7:0] MAX_LATENCY = 8'h18;
	localparam logic [7:0] INT_PIN_INTA = 8'h01;
	localparam logic [7:0] PM_CAP_ID = 8'h01;
	localparam logic [7:0] PM_NEXT_PTR = 8'h00;
	localparam logic [15:0] PM_CAP_VALUE = 16'h7e2a;
	localparam int CSR_PME_STATUS = 15;
	localparam int CSR_PME_EN = 8;
	localparam int CSR_STATE_LO = 0;
	localparam logic [1:0] PSTATE_RESET = 2'h0;
	localparam logic [7:0] INT_LINE_RESET = 8'h00;
	localparam logic [31:0] SUBSYS_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {
		PS_ON = 2'h0,
		PS_LIGHT = 2'h1,
		PS_MID = 2'h2,
		PS_HOT_DEEP = 2'h3
	} power_state_type;
endpackage

//--- tb.sv
// Testbench for the configuration header, power capability and interrupt merge.
// Assumes the host model drives every configuration cycle.
`timescale 1ns/1ps
module tb;
	import cfg_pm_pkg::*;
	localparam logic [15:0] POWER_CAPABILITY_HEADER = {1'h0, 4'hf, 2'h3, 3'h0, 1'h1, 1'h0, 1'h1, 3'h2};
	logic clk, nrst, cfg_valid, cfg_write, cfg_ack, ident_load, pme_event;
	logic inta_n, pme_oe_n, vc_strobe;
	logic [7:0] cfg_addr, src_event, buf_event;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, ident_data;
	logic [2:0] vc_number;
	power_state_type power_state;
	int mismatches = 0;
	int total_checks = 0;
	cfg_pm_block dut (.clk(clk), .nrst(nrst), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack), .ident_load(ident_load), .ident_data(ident_data),
		.pme_event(pme_event), .src_event(src_event), .buf_event(buf_event), .inta_n(inta_n),
		.pme_out(), .pme_oe_n(pme_oe_n), .power_state(power_state), .vc_strobe(vc_strobe),
		.vc_number(vc_number));
	cfg_host_model host (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One access; writes answer with zero data.
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, input logic [31:0] exp);
		logic [31:0] d;
		logic ok;
		host.xfer(w, a, be, wd, d, ok);
		if (ok !== 1'h1) begin
			mismatches++;
			tally_and_finish;
		end
		chk(d, exp);
	endtask
	// One-cycle event pulse, then let the taking edge settle.
	task automatic ev(input logic p, input logic il, input logic [7:0] s, input logic [7:0] b);
		@(posedge clk);
		pme_event <= p;
		ident_load <= il;
		src_event <= s;
		buf_event <= b;
		@(posedge clk);
		pme_event <= 1'h0;
		ident_load <= 1'h0;
		src_event <= 8'h00;
		buf_event <= 8'h00;
		#1;
	endtask
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		nrst = 1'h0;
		ident_load = 1'h0;
		pme_event = 1'h0;
		src_event = 8'h00;
		buf_event = 8'h00;
		ident_data = 32'h5a3c_c3a5;
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		acc(1'h0, 8'h40, 4'h0, 32'h0, {POWER_CAPABILITY_HEADER, 8'h00, 8'h01});
		acc(1'h0, 8'h44, 4'h0, 32'h0, 32'h0);
		acc(1'h1, 8'h40, 4'hf, 32'h0, 32'h0);
		acc(1'h0, 8'h40, 4'h0, 32'h0, {POWER_CAPABILITY_HEADER, 8'h00, 8'h01});
		acc(1'h1, 8'h44, 4'hf, 32'hffff_ffff, 32'h0);
		acc(1'h0, 8'h44, 4'h0, 32'h0, 32'h0000_0103);
		chk(32'(power_state), 32'h3);
		ev(1'h1, 1'h0, 8'h00, 8'h00);
		acc(1'h0, 8'h44, 4'h0, 32'h0, 32'h0000_8103);
		chk(32'(pme_oe_n), 32'h0);
		acc(1'h1, 8'h44, 4'h3, 32'h0000_8103, 32'h0);
		acc(1'h0, 8'h44, 4'h0, 32'h0, 32'h0000_0103);
		chk(32'(pme_oe_n), 32'h1);
		for (int s = 0; s < 4; s++) begin
			acc(1'h1, 8'h44, 4'h1, 32'(s), 32'h0);
			chk(32'(power_state), 32'(s));
		end
		acc(1'h0, 8'h2c, 4'h0, 32'h0, 32'h0);
		ev(1'h0, 1'h1, 8'h00, 8'h00);
		acc(1'h0, 8'h2c, 4'h0, 32'h0, 32'h5a3c_c3a5);
		acc(1'h1, 8'h2c, 4'hf, 32'h0f1e_2d3c, 32'h0);
		acc(1'h0, 8'h2c, 4'h0, 32'h0, 32'h0f1e_2d3c);
		ev(1'h0, 1'h0, 8'h24, 8'h00);
		chk(32'(inta_n), 32'h0);
		acc(1'h0, 8'h48, 4'h0, 32'h0, 32'h24);
		acc(1'h1, 8'h48, 4'h1, 32'h04, 32'h0);
		chk(32'(inta_n), 32'h0);
		acc(1'h0, 8'h48, 4'h0, 32'h0, 32'h20);
		acc(1'h1, 8'h48, 4'h1, 32'h20, 32'h0);
		chk(32'(inta_n), 32'h1);
		ev(1'h0, 1'h0, 8'h00, 8'h28);
		chk(32'({vc_strobe, vc_number}), 32'hb);
		chk(32'(inta_n), 32'h0);
		acc(1'h0, 8'h4c, 4'h0, 32'h0, 32'h28);
		acc(1'h1, 8'h4c, 4'h1, 32'h28, 32'h0);
		acc(1'h0, 8'h4c, 4'h0, 32'h0, 32'h0);
		chk(32'(inta_n), 32'h1);
		acc(1'h0, 8'h80, 4'h0, 32'h0, 32'h0);
		ev(1'h0, 1'h0, 8'h01, 8'h00);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		acc(1'h0, 8'h44, 4'h0, 32'h0, 32'h0);
		acc(1'h0, 8'h2c, 4'h0, 32'h0, 32'h0);
		chk(32'(inta_n), 32'h1);
		tally_and_finish;
	end
endmodule
